// *** logic/global_control_register_bank.sv ***
// Global control register bank behind the serial programming port
`timescale 1ns/1ps
module global_control_register_bank (
   input  wire logic        ref_clk_i,          // Core clock
   input  wire logic        arst_n_i,           // Async reset, active low
   input  wire logic        sclk_i,             // Serial clock
   input  wire logic        csb_n_i,            // Serial select, active low
   input  wire logic        sdio_i,             // Serial data in
   output logic             sdio_o,             // Serial data out
   output logic             sdio_oe_o,          // Serial data drive enable
   input  wire logic [3:0]  resync_state_i,     // Resync machine state
   input  wire logic        gpi_holdover_i,     // Holdover from input pin
   input  wire logic        debounce_bypass_i,  // Skip holdover debouncer
   input  wire logic        slip_done_i,        // Dividers finished slip
   input  wire logic        alarm_event_i,      // Other alarm source
   input  wire logic        sync_pin_i,         // Sync pin level
   input  wire logic        synth_lock_i,       // Synthesis loop locked
   output logic             divider_reset_o,    // Reset dividers and FSMs
   output logic             reseed_o,           // Reseed pulse
   output logic             slip_o,             // Slip pulse
   output logic             autotune_o,         // Autotune start pulse
   output logic             pulse_gen_o,        // Pulse stream request
   output logic             sync_event_o,       // Sync through synth loop
   output logic             lock_sync_o,        // Sync up feedback divider
   output logic             holdover_o,         // Loop in holdover
   output logic             phase_alarm_o,      // Latched phase sync alarm
   output logic             noise_priority_o,   // Noise priority path
   output logic             mute_o,             // Output drivers muted
   output logic             sleep_o,            // Device shut down
   output logic             io_buffer_en_o,     // Input/output buffers on
   output logic             reference_loop_en_o,// Reference loop enable
   output logic             synthesis_loop_en_o,// Synthesis loop enable
   output logic             timer_en_o,         // Timing reference enable
   output logic             rf_reseed_en_o,     // High-speed reseeder on
   output logic             osc_internal_high_o,// High core selected
   output logic             osc_internal_low_o, // Low core selected
   output logic             osc_external_o,     // External oscillator used
   output logic [13:0]      channel_en_o,       // Per-channel enables
   output logic             osc_input_mode_o,   // Second input as osc
   output logic             sync_input_mode_o,  // First input as sync
   output logic [3:0]       ref_path_en_o       // Reference path enables
);

   // Released reset copy
   logic              rst_ff1_r;
   logic              rst_n_r;
   // Register array
   logic [7:0]        regs_r [global_ctrl_pkg::NUM_REGS];
   // Serial port state
   global_ctrl_pkg::spi_state_t spi_state_r;
   logic              sclk_d_r;            // Previous serial clock
   logic [4:0]        bit_cnt_r;           // Bits taken in frame
   logic [23:0]       shift_in_r;          // Incoming frame
   logic [7:0]        shift_out_r;         // Read data being sent
   logic              rd_phase_r;          // Read data phase active
   logic              wr_stb_r;            // One-cycle write strobe
   logic [12:0]       wr_addr_r;           // Write address
   logic [7:0]        wr_data_r;           // Write data
   // Edge history of request bits and pins
   logic              reseed_d_r;
   logic              pulse_d_r;
   logic              slip_d_r;
   logic              tune_d_r;
   logic              sync_d_r;
   logic              lock_d_r;
   // Holdover debouncer
   logic [2:0]        hold_cnt_r;
   // Latched alarms
   logic              other_alarm_r;
   // Combinational helpers
   logic              sclk_rise;
   logic              soft_reset;
   logic              clear_alarms;
   logic              hold_req;
   logic [2:0]        hold_target;
   logic [1:0]        sync_mode;
   logic              sync_rise;
   logic              alarm_present;

   // Read decode of a register address
   function automatic logic [7:0] read_reg(input logic [12:0] addr,
                                           input logic [7:0] r0,
                                           input logic [7:0] r1,
                                           input logic [7:0] r2,
                                           input logic [7:0] r3,
                                           input logic [7:0] r4,
                                           input logic [7:0] r5,
                                           input logic [7:0] r6,
                                           input logic [7:0] r7,
                                           input logic [7:0] r8,
                                           input logic [7:0] r9);
      logic [7:0] d;
      case (addr)
         global_ctrl_pkg::ADDR_SOFT_RESET: d = r0;
         global_ctrl_pkg::ADDR_REQ_MODE:   d = r1;
         global_ctrl_pkg::ADDR_REQ_SECOND: d = r2;
         global_ctrl_pkg::ADDR_ENABLE:     d = r3;
         global_ctrl_pkg::ADDR_PAIR_EN:    d = r4;
         global_ctrl_pkg::ADDR_MODE_EN:    d = r5;
         global_ctrl_pkg::ADDR_ALARM_CLR:  d = r6;
         global_ctrl_pkg::ADDR_RSVD_MISC:  d = r7;
         global_ctrl_pkg::ADDR_SCRATCH:    d = r8;
         global_ctrl_pkg::ADDR_LOCK_SYNC:  d = r9;
         default:                          d = global_ctrl_pkg::UNMAPPED_DATA;
      endcase
      return d;
   endfunction : read_reg

   // Reset release through two flops
   always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         rst_ff1_r <= 1'b0;
         rst_n_r   <= 1'b0;
      end else begin
         rst_ff1_r <= 1'b1;
         rst_n_r   <= rst_ff1_r;
      end
   end

   // Serial clock edge detect
   assign sclk_rise = sclk_i & ~sclk_d_r;

   // Serial frame: rw, two length bits, 13 address bits, 8 data bits
   always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         spi_state_r <= global_ctrl_pkg::SP_IDLE;
         sclk_d_r    <= 1'b0;
         bit_cnt_r   <= 5'd0;
         shift_in_r  <= 24'h00_0000;
         shift_out_r <= 8'h00;
         rd_phase_r  <= 1'b0;
         wr_stb_r    <= 1'b0;
         wr_addr_r   <= 13'h0000;
         wr_data_r   <= 8'h00;
      end else begin
         sclk_d_r <= sclk_i;
         wr_stb_r <= 1'b0;
         case (spi_state_r)
            // Wait for select
            global_ctrl_pkg::SP_IDLE: begin
               bit_cnt_r  <= 5'd0;
               rd_phase_r <= 1'b0;
               if (!csb_n_i) begin
                  spi_state_r <= global_ctrl_pkg::SP_SHIFT;
               end
            end
            // Take one bit per serial clock rise
            global_ctrl_pkg::SP_SHIFT: begin
               if (csb_n_i) begin
                  spi_state_r <= global_ctrl_pkg::SP_IDLE;
               end else if (sclk_rise) begin
                  shift_in_r <= {shift_in_r[22:0], sdio_i};
                  bit_cnt_r  <= bit_cnt_r + 5'd1;
                  if (rd_phase_r) begin
                     shift_out_r <= {shift_out_r[6:0], 1'b0};
                  end
                  if (bit_cnt_r == global_ctrl_pkg::HEADER_BITS - 5'd1
                      && shift_in_r[14]) begin
                     // Header complete on a read: load data
                     rd_phase_r  <= 1'b1;
                     shift_out_r <= read_reg({shift_in_r[11:0], sdio_i},
                        regs_r[0], regs_r[1], regs_r[2], regs_r[3],
                        regs_r[4], regs_r[5], regs_r[6], regs_r[7],
                        regs_r[8], regs_r[9]);
                  end
                  if (bit_cnt_r == global_ctrl_pkg::FRAME_BITS - 5'd1) begin
                     spi_state_r <= global_ctrl_pkg::SP_DONE;
                     if (!shift_in_r[22]) begin
                        wr_stb_r  <= 1'b1;
                        wr_addr_r <= shift_in_r[19:7];
                        wr_data_r <= {shift_in_r[6:0], sdio_i};
                     end
                  end
               end
            end
            // Frame over, wait for deselect
            global_ctrl_pkg::SP_DONE: begin
               rd_phase_r <= 1'b0;
               if (csb_n_i) begin
                  spi_state_r <= global_ctrl_pkg::SP_IDLE;
               end
            end
            default: spi_state_r <= global_ctrl_pkg::SP_IDLE;
         endcase
      end
   end

   // Read data drive
   assign sdio_o    = shift_out_r[7];
   assign sdio_oe_o = rd_phase_r & ~csb_n_i;

   // Soft reset and alarm clear strobes
   assign soft_reset   = wr_stb_r
      && wr_addr_r == global_ctrl_pkg::ADDR_SOFT_RESET
      && wr_data_r[global_ctrl_pkg::BIT_SOFT_RESET];
   assign clear_alarms = wr_stb_r
      && wr_addr_r == global_ctrl_pkg::ADDR_ALARM_CLR
      && wr_data_r[global_ctrl_pkg::BIT_CLEAR_ALARMS];

   // Register writes; scratchpad is plain storage
   always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         for (int i = 0; i < global_ctrl_pkg::NUM_REGS; i++) begin
            regs_r[i] <= global_ctrl_pkg::REG_DEFAULT;
         end
      end else if (soft_reset) begin
         // Whole bank back to defaults, soft reset bit included
         for (int i = 0; i < global_ctrl_pkg::NUM_REGS; i++) begin
            regs_r[i] <= global_ctrl_pkg::REG_DEFAULT;
         end
      end else if (wr_stb_r
                   && wr_addr_r < 13'(global_ctrl_pkg::NUM_REGS)) begin
         regs_r[wr_addr_r[3:0]] <= wr_data_r;
      end
   end

   // Edge history, cleared by the hardware reset only, not by soft reset
   always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         reseed_d_r <= 1'b0;
         pulse_d_r  <= 1'b0;
         slip_d_r   <= 1'b0;
         tune_d_r   <= 1'b0;
         sync_d_r   <= 1'b0;
         lock_d_r   <= 1'b0;
      end else begin
         reseed_d_r <= regs_r[1][global_ctrl_pkg::BIT_RESEED];
         pulse_d_r  <= regs_r[1][global_ctrl_pkg::BIT_PULSE_GEN];
         slip_d_r   <= regs_r[2][global_ctrl_pkg::BIT_SLIP];
         tune_d_r   <= regs_r[2][global_ctrl_pkg::BIT_AUTOTUNE];
         sync_d_r   <= sync_pin_i;
         lock_d_r   <= synth_lock_i;
      end
   end

   // Sync pin decode
   assign sync_mode     = regs_r[5][7:global_ctrl_pkg::BIT_SYNC_MODE_LO];
   assign sync_rise     = sync_pin_i & ~sync_d_r;
   assign alarm_present = phase_alarm_o | other_alarm_r;

   // Request pulses toward dividers and loops
   always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         divider_reset_o <= 1'b0;
         reseed_o        <= 1'b0;
         slip_o          <= 1'b0;
         autotune_o      <= 1'b0;
         pulse_gen_o     <= 1'b0;
         sync_event_o    <= 1'b0;
         lock_sync_o     <= 1'b0;
      end else begin
         // Dividers reset on soft reset or restart
         divider_reset_o <= soft_reset
            | regs_r[1][global_ctrl_pkg::BIT_RESTART];
         // Reseed only on rise and while resync machine is in its done state
         reseed_o   <= regs_r[1][global_ctrl_pkg::BIT_RESEED] & ~reseed_d_r
            & (resync_state_i == global_ctrl_pkg::RESYNC_DONE);
         slip_o     <= regs_r[2][global_ctrl_pkg::BIT_SLIP]
            & ~slip_d_r;
         autotune_o <= regs_r[2][global_ctrl_pkg::BIT_AUTOTUNE]
            & ~tune_d_r;
         // Pulse stream from register or sync pin
         pulse_gen_o <= (regs_r[1][global_ctrl_pkg::BIT_PULSE_GEN]
                         & ~pulse_d_r)
            | (sync_rise & (sync_mode == global_ctrl_pkg::SYNC_PULSE
                 || (sync_mode == global_ctrl_pkg::SYNC_AUTO
                     && !alarm_present)));
         // Sync carried through the synthesis loop
         sync_event_o <= sync_rise
            & (sync_mode == global_ctrl_pkg::SYNC_SYNC
               || (sync_mode == global_ctrl_pkg::SYNC_AUTO
                   && alarm_present));
         // Sync up feedback divider on lock
         lock_sync_o <= synth_lock_i & ~lock_d_r
            & ~regs_r[9][global_ctrl_pkg::BIT_NO_LOCK_SYNC];
      end
   end

   // Latched alarms; a new event beats a clear
   always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         phase_alarm_o <= 1'b0;
         other_alarm_r <= 1'b0;
      end else begin
         if (slip_done_i) begin
            phase_alarm_o <= 1'b1;
         end else if (clear_alarms || soft_reset) begin
            phase_alarm_o <= 1'b0;
         end
         if (alarm_event_i) begin
            other_alarm_r <= 1'b1;
         end else if (clear_alarms || soft_reset) begin
            other_alarm_r <= 1'b0;
         end
      end
   end

   // Holdover request and debounce delay
   assign hold_req    = regs_r[1][global_ctrl_pkg::BIT_FORCE_HOLD]
                        | gpi_holdover_i;
   assign hold_target = debounce_bypass_i ? global_ctrl_pkg::HOLD_DLY_BYPASS
                                          : global_ctrl_pkg::HOLD_DLY_DEBOUNCE;

   // Request must stay high for the full delay
   always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         hold_cnt_r <= 3'd0;
         holdover_o <= 1'b0;
      end else if (!hold_req || soft_reset) begin
         hold_cnt_r <= 3'd0;
         holdover_o <= 1'b0;
      end else begin
         if (hold_cnt_r < hold_target) begin
            hold_cnt_r <= hold_cnt_r + 3'd1;
         end
         holdover_o <= (hold_cnt_r + 3'd1 >= hold_target);
      end
   end

   // Static controls straight from the registers
   always_ff @(posedge ref_clk_i or negedge rst_n_r) begin
      if (!rst_n_r) begin
         noise_priority_o    <= 1'b0;
         mute_o              <= 1'b0;
         sleep_o             <= 1'b0;
         io_buffer_en_o      <= 1'b0;
         reference_loop_en_o <= 1'b0;
         synthesis_loop_en_o <= 1'b0;
         timer_en_o          <= 1'b0;
         rf_reseed_en_o      <= 1'b0;
         osc_internal_high_o <= 1'b0;
         osc_internal_low_o  <= 1'b0;
         osc_external_o      <= 1'b0;
         channel_en_o        <= 14'h0000;
         osc_input_mode_o    <= 1'b0;
         sync_input_mode_o   <= 1'b0;
         ref_path_en_o       <= 4'h0;
      end else begin
         noise_priority_o <= regs_r[1][global_ctrl_pkg::BIT_NOISE_PRIO];
         mute_o  <= regs_r[1][global_ctrl_pkg::BIT_MUTE];
         sleep_o <= regs_r[1][global_ctrl_pkg::BIT_SLEEP];
         io_buffer_en_o <= ~regs_r[1][global_ctrl_pkg::BIT_SLEEP];
         // Loop enables, both forced off in sleep
         reference_loop_en_o <= regs_r[3][global_ctrl_pkg::BIT_REF_EN]
            & ~regs_r[1][global_ctrl_pkg::BIT_SLEEP];
         synthesis_loop_en_o <= regs_r[3][global_ctrl_pkg::BIT_SYNTH_EN]
            & ~regs_r[1][global_ctrl_pkg::BIT_SLEEP];
         timer_en_o     <= regs_r[3][global_ctrl_pkg::BIT_TIMER_EN];
         rf_reseed_en_o <= regs_r[3][global_ctrl_pkg::BIT_RF_RESEED_EN];
         // Oscillator core decode; code 11 selects nothing
         osc_external_o <= regs_r[3][4:global_ctrl_pkg::BIT_OSC_SEL_LO]
            == global_ctrl_pkg::OSC_EXT;
         osc_internal_high_o <= regs_r[3][4:global_ctrl_pkg::BIT_OSC_SEL_LO]
            == global_ctrl_pkg::OSC_HIGH;
         osc_internal_low_o <= regs_r[3][4:global_ctrl_pkg::BIT_OSC_SEL_LO]
            == global_ctrl_pkg::OSC_LOW;
         // Channel pairs, output network off in sleep
         for (int n = 0; n < 7; n++) begin
            channel_en_o[2*n]   <= regs_r[4][n]
               & ~regs_r[1][global_ctrl_pkg::BIT_SLEEP];
            channel_en_o[2*n+1] <= regs_r[4][n]
               & ~regs_r[1][global_ctrl_pkg::BIT_SLEEP];
         end
         osc_input_mode_o  <= regs_r[5][global_ctrl_pkg::BIT_OSC_IN_MODE];
         sync_input_mode_o <= regs_r[5][global_ctrl_pkg::BIT_RF_SYNC_MODE];
         ref_path_en_o <= regs_r[5][3:0]
            & {4{~regs_r[1][global_ctrl_pkg::BIT_SLEEP]}};
      end
   end

endmodule : global_control_register_bank

// *** logic/global_ctrl_pkg.sv ***
// Register map, field positions, defaults and timing of the global control bank
package global_ctrl_pkg;
   // Register offsets on the serial port
   localparam logic [12:0] ADDR_SOFT_RESET  = 13'h0000;
   localparam logic [12:0] ADDR_REQ_MODE    = 13'h0001;
   localparam logic [12:0] ADDR_REQ_SECOND  = 13'h0002;
   localparam logic [12:0] ADDR_ENABLE      = 13'h0003;
   localparam logic [12:0] ADDR_PAIR_EN     = 13'h0004;
   localparam logic [12:0] ADDR_MODE_EN     = 13'h0005;
   localparam logic [12:0] ADDR_ALARM_CLR   = 13'h0006;
   localparam logic [12:0] ADDR_RSVD_MISC   = 13'h0007;
   localparam logic [12:0] ADDR_SCRATCH     = 13'h0008;
   localparam logic [12:0] ADDR_LOCK_SYNC   = 13'h0009;
   localparam int          NUM_REGS         = 10;
   // Value after reset of every register
   localparam logic [7:0]  REG_DEFAULT      = 8'h00;
   localparam logic [7:0]  UNMAPPED_DATA    = 8'h00;
   // Soft reset register
   localparam int BIT_SOFT_RESET    = 0;
   // Request and mode register
   localparam int BIT_RESEED        = 7;
   localparam int BIT_NOISE_PRIO    = 6;
   localparam int BIT_FORCE_HOLD    = 4;
   localparam int BIT_MUTE          = 3;
   localparam int BIT_PULSE_GEN     = 2;
   localparam int BIT_RESTART       = 1;
   localparam int BIT_SLEEP         = 0;
   // Secondary request register
   localparam int BIT_AUTOTUNE      = 2;
   localparam int BIT_SLIP          = 1;
   // Enable register
   localparam int BIT_RF_RESEED_EN  = 5;
   localparam int BIT_OSC_SEL_LO    = 3;
   localparam int BIT_TIMER_EN      = 2;
   localparam int BIT_SYNTH_EN      = 1;
   localparam int BIT_REF_EN        = 0;
   // Mode and enable register
   localparam int BIT_SYNC_MODE_LO  = 6;
   localparam int BIT_OSC_IN_MODE   = 5;
   localparam int BIT_RF_SYNC_MODE  = 4;
   // Alarm clear and lock sync
   localparam int BIT_CLEAR_ALARMS  = 0;
   localparam int BIT_NO_LOCK_SYNC  = 0;
   // Resync machine done state
   localparam logic [3:0] RESYNC_DONE = 4'h2;
   // Sync pin modes
   localparam logic [1:0] SYNC_OFF    = 2'b00;
   localparam logic [1:0] SYNC_SYNC   = 2'b01;
   localparam logic [1:0] SYNC_PULSE  = 2'b10;
   localparam logic [1:0] SYNC_AUTO   = 2'b11;
   // Oscillator selection codes
   localparam logic [1:0] OSC_EXT     = 2'b00;
   localparam logic [1:0] OSC_HIGH    = 2'b01;
   localparam logic [1:0] OSC_LOW     = 2'b10;
   // Holdover entry delays in core clock cycles
   localparam logic [2:0] HOLD_DLY_DEBOUNCE = 3'd6;
   localparam logic [2:0] HOLD_DLY_BYPASS   = 3'd2;
   // Serial frame layout
   localparam logic [4:0] FRAME_BITS  = 5'd24;
   localparam logic [4:0] HEADER_BITS = 5'd16;
   // Serial port states
   typedef enum logic [2:0] {
      SP_IDLE  = 3'b001,
      SP_SHIFT = 3'b010,
      SP_DONE  = 3'b100
   } spi_state_t;
endpackage : global_ctrl_pkg

// *** test/global_control_register_bank_bench.sv ***
// Self-checking bench of the global control register bank
`timescale 1ns/1ps
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin \
   fail_count++; $display("ERROR %s exp %h got %h", n, e, g); end end
module global_control_register_bank_bench;
   logic ref_clk_i = 0, arst_n_i = 0, sclk_i, csb_n_i, sdio_i, sdio_o, sdio_d;
   logic sdio_oe_o, gpi_holdover_i = 0, debounce_bypass_i = 0, slip_done_i = 0;
   logic alarm_event_i = 0, sync_pin_i = 0, synth_lock_i = 0, divider_reset_o;
   logic reseed_o, slip_o, autotune_o, pulse_gen_o, sync_event_o, lock_sync_o;
   logic holdover_o, phase_alarm_o, mute_o, noise_priority_o, sleep_o;
   logic io_buffer_en_o, timer_en_o, reference_loop_en_o, synthesis_loop_en_o;
   logic rf_reseed_en_o, osc_internal_high_o, osc_internal_low_o;
   logic osc_external_o, osc_input_mode_o, sync_input_mode_o;
   logic [3:0]  resync_state_i = 4'h0, ref_path_en_o;
   logic [13:0] channel_en_o;
   logic [7:0]  q;
   logic [5:0]  pv;
   int          fail_count = 0, total_checks = 0, cnt[6] = '{default: 0};
   always #2.5 ref_clk_i = ~ref_clk_i;
   assign sdio_i = sdio_oe_o ? sdio_o : sdio_d;
   assign pv = {lock_sync_o, sync_event_o, pulse_gen_o, autotune_o, slip_o,
                reseed_o};
   // Grouped static outputs for the compares
   wire [2:0]  osc_v   = {osc_internal_high_o, osc_internal_low_o,
                          osc_external_o};
   wire [3:0]  en_v    = {reference_loop_en_o, synthesis_loop_en_o,
                          timer_en_o, rf_reseed_en_o};
   wire [5:0]  mode_v  = {osc_input_mode_o, sync_input_mode_o, ref_path_en_o};
   wire [19:0] sleep_v = {sleep_o, io_buffer_en_o, channel_en_o,
                          ref_path_en_o};
   // Cycles each request pulse stood high
   always @(posedge ref_clk_i) foreach (cnt[i]) cnt[i] += int'(pv[i]);
   global_control_register_bank dut (.*);
   global_ctrl_host host (.ref_clk_i, .wire_i(sdio_i), .sclk_o(sclk_i),
                          .csb_n_o(csb_n_i), .sdio_d_o(sdio_d));
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      host.xfer(1'b0, a, d, q);
   endtask : wr
   task automatic rd(input logic [12:0] a, input logic [7:0] e);
      host.xfer(1'b1, a, 8'h00, q);
      `CHK("read", e, q)
   endtask : rd
   // Set one request bit, count its pulses, then clear it
   task automatic pulse(input int i, input logic [12:0] a, input logic [7:0] d,
                        input int e);
      cnt[i] = 0;
      wr(a, d);
      `CHK("pulse", e, cnt[i])
      wr(a, 8'h00);
   endtask : pulse
   // Rising edge on sync pin and lock together
   task automatic pin(input int i, input int e);
      cnt[i] = 0;
      {sync_pin_i, synth_lock_i} = 2'h3;
      repeat (6) @(negedge ref_clk_i);
      `CHK("edge", e, cnt[i])
      {sync_pin_i, synth_lock_i} = 2'h0;
      repeat (2) @(negedge ref_clk_i);
   endtask : pin
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   initial begin
      repeat (100000) @(posedge ref_clk_i);
      fail_count++;
      final_report();
   end
   initial begin
      repeat (10) @(negedge ref_clk_i);
      arst_n_i = 1'b1;
      repeat (4) @(negedge ref_clk_i);
      for (int a = 0; a < 11; a++)
         rd(13'(a), 8'h00);
      wr(13'h0008, 8'hA5);
      rd(13'h0008, 8'hA5);
      wr(13'h000A, 8'hFF);
      rd(13'h000A, 8'h00);
      wr(13'h0003, 8'h2F);
      `CHK("en", 7'h7C, {en_v, osc_v})
      wr(13'h0003, 8'h10);
      `CHK("osc", 3'h2, osc_v)
      wr(13'h0003, 8'h18);
      `CHK("osc", 3'h0, osc_v)
      wr(13'h0004, 8'hD5);
      `CHK("pairs", 14'h3333, channel_en_o)
      wr(13'h0005, 8'h35);
      `CHK("modes", 6'h35, mode_v)
      wr(13'h0001, 8'h48);
      `CHK("mute", 2'h3, {noise_priority_o, mute_o})
      wr(13'h0001, 8'h01);
      `CHK("sleep", 20'h8_0000, sleep_v)
      wr(13'h0001, 8'h02);
      `CHK("restart", 1'b1, divider_reset_o)
      rd(13'h0004, 8'hD5);
      pulse(2, 13'h0002, 8'h04, 1);
      pulse(3, 13'h0001, 8'h04, 1);
      pulse(1, 13'h0002, 8'h02, 1);
      resync_state_i = 4'h1;
      pulse(0, 13'h0001, 8'h80, 0);
      resync_state_i = 4'h2;
      pulse(0, 13'h0001, 8'h80, 1);
      pin(4, 0);
      pin(5, 1);
      wr(13'h0009, 8'h01);
      pin(5, 0);
      wr(13'h0005, 8'h40);
      pin(4, 1);
      wr(13'h0005, 8'hC0);
      pin(3, 1);
      slip_done_i = 1'b1;
      @(negedge ref_clk_i);
      slip_done_i = 1'b0;
      pin(4, 1);
      `CHK("alarm", 1'b1, phase_alarm_o)
      wr(13'h0006, 8'h01);
      `CHK("clear", 1'b0, phase_alarm_o)
      wr(13'h0006, 8'h00);
      // Other alarm source steers mode 11 to sync until cleared
      alarm_event_i = 1'b1;
      @(negedge ref_clk_i);
      alarm_event_i = 1'b0;
      pin(4, 1);
      wr(13'h0006, 8'h01);
      pin(3, 1);
      for (int b = 0; b < 2; b++) begin
         debounce_bypass_i = b[0];
         gpi_holdover_i = 1'b1;
         repeat (12) @(negedge ref_clk_i);
         `CHK("hold", 1'b1, holdover_o)
         gpi_holdover_i = 1'b0;
         repeat (3) @(negedge ref_clk_i);
      end
      wr(13'h0001, 8'h10);
      `CHK("force", 1'b1, holdover_o)
      wr(13'h0000, 8'h01);
      rd(13'h0008, 8'h00);
      final_report();
   end
endmodule : global_control_register_bank_bench

// *** test/global_ctrl_asserts.sv ***
// Port assertions of the global control bank
`timescale 1ns/1ps
module global_ctrl_asserts (
   input wire logic        ref_clk_i,
   input wire logic        arst_n_i,
   input wire logic        csb_n_i,
   input wire logic [3:0]  resync_state_i,
   input wire logic        gpi_holdover_i,
   input wire logic        debounce_bypass_i,
   input wire logic        slip_done_i,
   input wire logic        reseed_o,
   input wire logic        holdover_o,
   input wire logic        phase_alarm_o,
   input wire logic        sleep_o,
   input wire logic        io_buffer_en_o,
   input wire logic [13:0] channel_en_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!arst_n_i);
   // Steady bypassed request, and a quiet serial port
   sequence s_fast; (gpi_holdover_i && debounce_bypass_i)[*8]; endsequence
   sequence s_quiet; csb_n_i[*4]; endsequence
   property p_hold_fast; s_fast |-> holdover_o; endproperty
   property p_hold_slow; $rose(gpi_holdover_i) && !debounce_bypass_i
      && !holdover_o |=> (!holdover_o)[*5]; endproperty
   property p_alarm_set; slip_done_i |=> phase_alarm_o; endproperty
   property p_alarm_keep; s_quiet ##0 phase_alarm_o |=> phase_alarm_o;
   endproperty
   property p_reseed; reseed_o |-> $past(resync_state_i) == 4'h2; endproperty
   property p_sleep; sleep_o && $past(sleep_o) |-> !io_buffer_en_o;
   endproperty
   property p_sleep_ch; sleep_o && $past(sleep_o) |-> channel_en_o == 0;
   endproperty
   property p_pairs; (channel_en_o & 14'h1555) ==
      ((channel_en_o >> 1) & 14'h1555); endproperty
   a_hold_fast: assert property (p_hold_fast) else $error("late");
   a_hold_slow: assert property (p_hold_slow) else $error("early");
   a_alarm_set: assert property (p_alarm_set) else $error("set");
   a_alarm_keep: assert property (p_alarm_keep) else $error("lost");
   a_reseed: assert property (p_reseed) else $error("reseed");
   a_sleep: assert property (p_sleep) else $error("buffers");
   a_sleep_ch: assert property (p_sleep_ch) else $error("outputs");
   a_pairs: assert property (p_pairs) else $error("pairs");
endmodule : global_ctrl_asserts
bind global_control_register_bank global_ctrl_asserts u_chk (.*);

// *** test/global_ctrl_host.sv ***
// Host model that drives the serial programming port
`timescale 1ns/1ps
module global_ctrl_host (
   input  wire logic ref_clk_i, // Core clock
   input  wire logic wire_i,    // Data line level
   output logic      sclk_o,    // Serial clock
   output logic      csb_n_o,   // Select, active low
   output logic      sdio_d_o   // Host data drive
);
   initial begin
      sclk_o = 1'b0;
      csb_n_o = 1'b1;
      sdio_d_o = 1'b0;
   end
   // One frame, each serial level held two clocks; entered at a falling edge
   task automatic xfer(input logic rw, input logic [12:0] a,
                       input logic [7:0] d, output logic [7:0] q);
      logic [23:0] f;
      f = {rw, 2'h0, a, d};
      csb_n_o = 1'b0;
      for (int i = 23; i >= 0; i--) begin
         sdio_d_o = f[i];
         repeat (2) @(negedge ref_clk_i);
         // Read bit taken just before its rise
         if (i < 8) q[i] = wire_i;
         sclk_o = 1'b1;
         repeat (2) @(negedge ref_clk_i);
         sclk_o = 1'b0;
      end
      repeat (2) @(negedge ref_clk_i);
      csb_n_o = 1'b1;
      // Released line shows no stale level
      sdio_d_o = ~sdio_d_o;
      repeat (4) @(negedge ref_clk_i);
   endtask : xfer
endmodule : global_ctrl_host
